// >>> inc/tpw_pkg.sv
// package for the three-phase pwm update timing block: register map,
// field positions, reset values and the phase state encoding.
// assumes a 32-bit apb slave with byte addresses on paddr[7:0].
package tpw_pkg;

    // register byte offsets, one aligned word each
    localparam logic [7:0] TPW_OFS_MODE = 8'h00; // mode_control_reg
    localparam logic [7:0] TPW_OFS_STATUS = 8'h04; // system_status_reg, read only
    localparam logic [7:0] TPW_OFS_HALF_PERIOD = 8'h08; // half_period_reg
    localparam logic [7:0] TPW_OFS_DEAD_TIME = 8'h0C; // dead_time_reg
    localparam logic [7:0] TPW_OFS_MIN_PULSE = 8'h10; // min_pulse_reg
    localparam logic [7:0] TPW_OFS_SYNC_WIDTH = 8'h14; // sync_width_reg
    localparam logic [7:0] TPW_OFS_DUTY_A = 8'h18; // duty_phase_a
    localparam logic [7:0] TPW_OFS_DUTY_B = 8'h1C; // duty_phase_b
    localparam logic [7:0] TPW_OFS_DUTY_C = 8'h20; // duty_phase_c
    localparam logic [7:0] TPW_OFS_OUT_SEL = 8'h24; // output_select_reg

    // field positions
    localparam int TPW_MODE_DOUBLE_BIT = 6; // mode select: 0 single, 1 double
    localparam int TPW_STAT_HALF_BIT = 3; // second half of period
    localparam int TPW_STAT_RUN_BIT = 0; // outputs enabled
    localparam int TPW_SEG_XOVER_BASE = 8; // phase a crossover, b and c below
    localparam int TPW_SEG_DIS_HI_BASE = 5; // phase a high disable, steps of two
    localparam int TPW_SEG_DIS_LO_BASE = 4; // phase a low disable, steps of two
    localparam int TPW_SEG_W = 9; // output select width

    // reset values
    localparam logic [7:0] TPW_SYNC_WIDTH_RST = 8'h27; // forty clock periods
    localparam logic TPW_MODE_DOUBLE_RST = 1'b0; // single update after reset
    localparam logic [8:0] TPW_OUT_SEL_RST = 9'h000; // no crossover, all enabled

    // phase of the up/down timer
    typedef enum logic [2:0] {
        TPW_PH_IDLE = 3'b001, // timer not yet started
        TPW_PH_FIRST = 3'b010, // counting up, first half
        TPW_PH_SECOND = 3'b100 // counting down, second half
    } tpw_phase_t;

endpackage : tpw_pkg

// >>> src/tpw_timing.sv
// three-phase center-based pwm timing unit with apb register access,
// single/double update, sync pulse generation and dead-time placement.
// assumes one clock pclk at the instruction rate and an apb master.
//
// Overview of operation
// - mode bit selects single or double update
// - mode bit resets to single update
// - single mode: one sync, latches all timing
// - sync rising edge latches output select
// - double mode: midpoint sync reloads all but the mode bit
// - half flag low first half, high second
// - sync high for width plus one clocks
// - sync width resets to 0x27
// - sync once or twice per period out
// - duty sets half-period high-side on-time
// - waveforms centered, symmetrical in single mode
// - dead time shifts each edge equally
// - on-times follow duty minus dead-time equations
// - on-times clamp between zero and period
// - double period is sum of halves
// - double mode dead time per half values
// - outputs off until period and duties written
// - first sync 1.5 or 1 half-period after
// - half-period counts clocks per half period
// - interrupt request pulse on each sync
// - everything timed in pclk periods
//
// The register offsets and register access over APB are this design's own decisions.
module tpw_timing
    import tpw_pkg::*;
#(
    parameter int CNT_W = 16, // half period and duty width
    parameter int DT_W = 10, // dead time width
    parameter int SW_W = 8 // sync width register width
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic phase_a_high_out,
    output logic phase_a_low_out,
    output logic phase_b_high_out,
    output logic phase_b_low_out,
    output logic phase_c_high_out,
    output logic phase_c_low_out,
    output logic period_sync_pulse,
    output logic sync_irq
);

    // refuse widths the threshold arithmetic cannot hold
    if (CNT_W < 2 || CNT_W > 30 || DT_W > CNT_W || SW_W > CNT_W || SW_W < 8) begin : g_chk
        $error("tpw_timing: unsupported width parameters");
    end

    localparam int TW = CNT_W + 2; // signed threshold width

    // holding copies written by software
    logic mode_double_q; // mode select bit
    logic [CNT_W-1:0] half_period_q;
    logic [DT_W-1:0] dead_time_q;
    logic [CNT_W-1:0] min_pulse_q; // stored only, no pulse elimination here
    logic [SW_W-1:0] sync_width_q;
    logic [2:0][CNT_W-1:0] duty_q; // index 0 a, 1 b, 2 c
    logic [TPW_SEG_W-1:0] out_sel_q;

    // active copies used by the timer
    logic mode_act_q;
    logic [CNT_W-1:0] half_act_q;
    logic [DT_W-1:0] dead_act_q;
    logic [CNT_W-1:0] min_act_q;
    logic [SW_W-1:0] width_act_q;
    logic [2:0][CNT_W-1:0] duty_act_q;
    logic [TPW_SEG_W-1:0] sel_act_q;

    // start-up tracking
    logic [3:0] written_q; // half period, duty a, b, c seen
    logic run_q; // outputs enabled

    // timer
    tpw_phase_t phase_q;
    logic [CNT_W-1:0] cnt_q;
    logic half_flag_q; // second half indicator
    logic [SW_W-1:0] sync_cnt_q;
    logic sync_q;
    logic irq_q;

    // apb
    logic ready_q;
    logic [31:0] rdata_q;
    logic err_q;
    logic [31:0] rd_data; // combinational read value
    logic rd_hit; // address is mapped
    logic wr_en; // write commits this edge
    logic access; // access phase waiting

    // timer events
    logic first_wr; // first half period write, timer start
    logic mid_ev; // first half ends
    logic start_ev; // period begins
    logic latch_ev; // holding copies move to active
    logic [CNT_W-1:0] half_last; // last count of a half

    // waveform
    logic [2:0] hi_raw;
    logic [2:0] lo_raw;
    logic [5:0] pins_d; // ah, al, bh, bl, ch, cl
    logic [5:0] pins_q;

    // last count in a half, a zero half period acts as one clock
    function automatic logic [CNT_W-1:0] last_of(input logic [CNT_W-1:0] tm);
        last_of = (tm == '0) ? '0 : tm - CNT_W'(1);
    endfunction : last_of

    // apb control: one wait state, answer always comes from flops
    assign access = psel && penable;
    assign wr_en = access && pwrite && ready_q;

    // address decode and read mux
    always_comb begin
        rd_data = 32'h0000_0000;
        rd_hit = 1'b1;
        case (paddr)
            TPW_OFS_MODE: rd_data[TPW_MODE_DOUBLE_BIT] = mode_double_q;
            TPW_OFS_STATUS: begin
                rd_data[TPW_STAT_HALF_BIT] = half_flag_q;
                rd_data[TPW_STAT_RUN_BIT] = run_q;
            end
            TPW_OFS_HALF_PERIOD: rd_data[CNT_W-1:0] = half_period_q;
            TPW_OFS_DEAD_TIME: rd_data[DT_W-1:0] = dead_time_q;
            TPW_OFS_MIN_PULSE: rd_data[CNT_W-1:0] = min_pulse_q;
            TPW_OFS_SYNC_WIDTH: rd_data[SW_W-1:0] = sync_width_q;
            TPW_OFS_DUTY_A: rd_data[CNT_W-1:0] = duty_q[0];
            TPW_OFS_DUTY_B: rd_data[CNT_W-1:0] = duty_q[1];
            TPW_OFS_DUTY_C: rd_data[CNT_W-1:0] = duty_q[2];
            TPW_OFS_OUT_SEL: rd_data[TPW_SEG_W-1:0] = out_sel_q;
            default: rd_hit = 1'b0; // unmapped: zero data, error
        endcase
    end

    // apb answer flops: ready rises one cycle into the access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ready_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            err_q <= 1'b0;
        end else if (access && !ready_q) begin
            ready_q <= 1'b1;
            rdata_q <= pwrite ? 32'h0000_0000 : rd_data;
            err_q <= !rd_hit;
        end else begin
            ready_q <= 1'b0; // answer lasts exactly one cycle
            err_q <= 1'b0;
        end
    end

    // software holding registers; nothing here touches the live waveform
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_double_q <= TPW_MODE_DOUBLE_RST;
            half_period_q <= '0;
            dead_time_q <= '0;
            min_pulse_q <= '0;
            sync_width_q <= SW_W'(TPW_SYNC_WIDTH_RST);
            duty_q <= '0;
            out_sel_q <= TPW_OUT_SEL_RST;
        end else if (wr_en) begin
            case (paddr)
                TPW_OFS_MODE: mode_double_q <= pwdata[TPW_MODE_DOUBLE_BIT];
                TPW_OFS_HALF_PERIOD: half_period_q <= pwdata[CNT_W-1:0];
                TPW_OFS_DEAD_TIME: dead_time_q <= pwdata[DT_W-1:0];
                TPW_OFS_MIN_PULSE: min_pulse_q <= pwdata[CNT_W-1:0];
                TPW_OFS_SYNC_WIDTH: sync_width_q <= pwdata[SW_W-1:0];
                TPW_OFS_DUTY_A: duty_q[0] <= pwdata[CNT_W-1:0];
                TPW_OFS_DUTY_B: duty_q[1] <= pwdata[CNT_W-1:0];
                TPW_OFS_DUTY_C: duty_q[2] <= pwdata[CNT_W-1:0];
                TPW_OFS_OUT_SEL: out_sel_q <= pwdata[TPW_SEG_W-1:0];
                default: ; // status and unmapped writes are dropped
            endcase
        end
    end

    // remember which start-up registers have been written
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            written_q <= 4'h0;
        end else if (wr_en) begin
            if (paddr == TPW_OFS_HALF_PERIOD) written_q[0] <= 1'b1;
            if (paddr == TPW_OFS_DUTY_A) written_q[1] <= 1'b1;
            if (paddr == TPW_OFS_DUTY_B) written_q[2] <= 1'b1;
            if (paddr == TPW_OFS_DUTY_C) written_q[3] <= 1'b1;
        end
    end

    // timer events
    assign first_wr = wr_en && (paddr == TPW_OFS_HALF_PERIOD) && (phase_q == TPW_PH_IDLE);
    assign half_last = last_of(half_act_q);
    assign mid_ev = (phase_q == TPW_PH_FIRST) && (cnt_q == half_last);
    assign start_ev = (phase_q == TPW_PH_SECOND) && (cnt_q == '0);
    // the midpoint reloads only in double update mode
    assign latch_ev = start_ev || (mid_ev && mode_act_q);

    // up/down timer: up through the first half, down through the second
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_q <= TPW_PH_IDLE;
            cnt_q <= '0;
        end else begin
            case (phase_q)
                TPW_PH_IDLE: begin
                    if (first_wr) begin
                        phase_q <= TPW_PH_FIRST;
                        // single mode starts mid first half, so the first sync
                        // comes 1.5 half periods later; double starts at zero
                        cnt_q <= mode_double_q ? '0 : (pwdata[CNT_W-1:0] >> 1);
                    end
                end
                TPW_PH_FIRST: begin
                    if (mid_ev) begin
                        phase_q <= TPW_PH_SECOND;
                        // second half length comes from the values for that half
                        cnt_q <= mode_act_q ? last_of(half_period_q) : half_last;
                    end else begin
                        cnt_q <= cnt_q + CNT_W'(1);
                    end
                end
                TPW_PH_SECOND: begin
                    if (start_ev) begin
                        phase_q <= TPW_PH_FIRST;
                        cnt_q <= '0;
                    end else begin
                        cnt_q <= cnt_q - CNT_W'(1);
                    end
                end
                default: begin
                    phase_q <= TPW_PH_IDLE;
                    cnt_q <= '0;
                end
            endcase
        end
    end

    // half flag follows the timer phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            half_flag_q <= 1'b0;
        end else if (mid_ev) begin
            half_flag_q <= 1'b1;
        end else if (start_ev) begin
            half_flag_q <= 1'b0;
        end
    end

    // active copies: loaded at every sync rising edge, the mode bit at period starts only; the half period
    // and mode bit once at timer start so the first count has a bound
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_act_q <= TPW_MODE_DOUBLE_RST;
            half_act_q <= '0;
            dead_act_q <= '0;
            min_act_q <= '0;
            width_act_q <= SW_W'(TPW_SYNC_WIDTH_RST);
            duty_act_q <= '0;
            sel_act_q <= TPW_OUT_SEL_RST;
        end else if (first_wr) begin
            mode_act_q <= mode_double_q;
            half_act_q <= pwdata[CNT_W-1:0];
        end else if (latch_ev) begin
            // mode changes only at a period start, never mid-period
            if (start_ev) mode_act_q <= mode_double_q;
            half_act_q <= half_period_q;
            dead_act_q <= dead_time_q;
            min_act_q <= min_pulse_q;
            width_act_q <= sync_width_q;
            duty_act_q <= duty_q;
            sel_act_q <= out_sel_q;
        end
    end

    // outputs come alive only at a sync edge once all four are written
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_q <= 1'b0;
        end else if (latch_ev && (written_q == 4'hF)) begin
            run_q <= 1'b1;
        end
    end

    // sync pulse: high for width plus one clocks, restarted by each event
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_q <= 1'b0;
            sync_cnt_q <= '0;
        end else if (latch_ev) begin
            sync_q <= 1'b1;
            sync_cnt_q <= sync_width_q;
        end else if (sync_q) begin
            if (sync_cnt_q == '0) begin
                sync_q <= 1'b0;
            end else begin
                sync_cnt_q <= sync_cnt_q - SW_W'(1);
            end
        end
    end

    // interrupt request: one pulse per sync rising edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= latch_ev;
        end
    end

    // per-phase edge placement; the same counter value in both halves
    // mirrors each edge about the midpoint
    for (genvar i = 0; i < 3; i++) begin : g_phase
        logic signed [TW-1:0] cnt_s;
        logic signed [TW-1:0] hi_thr;
        logic signed [TW-1:0] lo_thr;
        assign cnt_s = $signed({2'b00, cnt_q});
        // high side on for duty minus dead time counts next to the midpoint
        assign hi_thr = $signed({2'b00, half_act_q}) - $signed({2'b00, duty_act_q[i]})
                        + $signed(TW'(dead_act_q));
        // low side on for half period minus duty minus dead time counts
        assign lo_thr = $signed({2'b00, half_act_q}) - $signed({2'b00, duty_act_q[i]})
                        - $signed(TW'(dead_act_q));
        // signed thresholds below zero or past the half give 100% or 0%
        assign hi_raw[i] = (cnt_s >= hi_thr);
        assign lo_raw[i] = (cnt_s < lo_thr);
    end

    // output control: crossover then disable, all from latched select
    always_comb begin
        pins_d = 6'h00;
        for (int i = 0; i < 3; i++) begin
            if (sel_act_q[TPW_SEG_XOVER_BASE - i]) begin
                pins_d[5 - 2 * i] = lo_raw[i];
                pins_d[4 - 2 * i] = hi_raw[i];
            end else begin
                pins_d[5 - 2 * i] = hi_raw[i];
                pins_d[4 - 2 * i] = lo_raw[i];
            end
            // disable gates the crossover result
            if (sel_act_q[TPW_SEG_DIS_HI_BASE - 2 * i]) pins_d[5 - 2 * i] = 1'b0;
            if (sel_act_q[TPW_SEG_DIS_LO_BASE - 2 * i]) pins_d[4 - 2 * i] = 1'b0;
        end
    end

    // output flops; held low until the unit runs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pins_q <= 6'h00;
        end else begin
            pins_q <= run_q ? pins_d : 6'h00;
        end
    end

    // port mapping, all straight from flops
    assign phase_a_high_out = pins_q[5];
    assign phase_a_low_out = pins_q[4];
    assign phase_b_high_out = pins_q[3];
    assign phase_b_low_out = pins_q[2];
    assign phase_c_high_out = pins_q[1];
    assign phase_c_low_out = pins_q[0];
    assign period_sync_pulse = sync_q;
    assign sync_irq = irq_q;
    assign prdata = rdata_q;
    assign pready = ready_q;
    assign pslverr = err_q;

endmodule : tpw_timing

// >>> verif/tpw_timing_props.sv
// checker: apb handshake, sync pulse, irq and gate outputs of tpw_timing.
// assumes it is bound to tpw_timing and sees only that module's ports.
module tpw_timing_props
    import tpw_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic phase_a_high_out,
    input wire logic phase_a_low_out,
    input wire logic phase_b_high_out,
    input wire logic phase_b_low_out,
    input wire logic phase_c_high_out,
    input wire logic phase_c_low_out,
    input wire logic period_sync_pulse,
    input wire logic sync_irq
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [8:0] hi_q; // cycles sync has stayed high
    logic sw_q; // sync width written since reset
    logic run_q; // a sync has been seen
    logic [5:0] g; // gate outputs, a high on top
    assign g = {phase_a_high_out, phase_a_low_out, phase_b_high_out,
                phase_b_low_out, phase_c_high_out, phase_c_low_out};
    // run length of the sync pulse
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hi_q <= 9'h000;
        end else begin
            hi_q <= period_sync_pulse ? hi_q + 9'h001 : 9'h000;
        end
    end
    // history flags; the default width check stops once software moves it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sw_q <= 1'b0;
            run_q <= 1'b0;
        end else begin
            sw_q <= sw_q | (psel & penable & pready & pwrite & (paddr == TPW_OFS_SYNC_WIDTH));
            run_q <= run_q | period_sync_pulse;
        end
    end
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // one wait state, then ready
    sequence s_wait_ready;
        !pready ##1 pready;
    endsequence
    property p_ready_wait;
        psel && $rose(penable) |-> s_wait_ready;
    endproperty
    a_ready_wait: assert property (p_ready_wait) else $error("pready late or early");
    property p_ready_pulse;
        pready |=> !pready;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("pready held");
    property p_err_ready;
        pslverr |-> pready && psel && penable;
    endproperty
    a_err_ready: assert property (p_err_ready) else $error("pslverr outside access");
    property p_irq_rise;
        $rose(period_sync_pulse) |-> sync_irq;
    endproperty
    a_irq_rise: assert property (p_irq_rise) else $error("no irq on sync");
    property p_irq_only;
        sync_irq |-> $rose(period_sync_pulse);
    endproperty
    a_irq_only: assert property (p_irq_only) else $error("stray irq");
    property p_sync_default;
        $fell(period_sync_pulse) && !sw_q |-> hi_q == 9'h028;
    endproperty
    a_sync_default: assert property (p_sync_default) else $error("sync width wrong");
    property p_off_before_run;
        !run_q && !period_sync_pulse |-> g == 6'h00;
    endproperty
    a_off_before_run: assert property (p_off_before_run) else $error("early gate");
    property p_no_overlap;
        !(g[5] && g[4]) && !(g[3] && g[2]) && !(g[1] && g[0]);
    endproperty
    a_no_overlap: assert property (p_no_overlap) else $error("both gates on");
endmodule : tpw_timing_props

bind tpw_timing tpw_timing_props u_props (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .phase_a_high_out, .phase_a_low_out, .phase_b_high_out,
    .phase_b_low_out, .phase_c_high_out, .phase_c_low_out, .period_sync_pulse, .sync_irq
);

// >>> verif/tpw_gate_model.sv
// far side model: gate drivers and the converter sampler.
// assumes one clock; counts gate on-cycles between sync rises.
module tpw_gate_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [5:0] gate,
    input wire logic sync,
    output logic [5:0][15:0] hi_snap,
    output logic [15:0] gap_snap,
    output logic [15:0] len_snap,
    output logic [15:0] rises
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [5:0][15:0] run_q; // on-cycles in the current window
    logic [15:0] gap_q; // cycles since the last rise
    logic [15:0] len_q; // cycles sync has been high
    logic sync_q; // sync one sample back
    // a sampler sees only edges, so each window runs rise to rise
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {run_q, hi_snap, gap_q, gap_snap, len_q, len_snap, rises, sync_q} <= '0;
        end else begin
            sync_q <= sync;
            len_q <= sync ? len_q + 16'h0001 : 16'h0000;
            if (!sync && sync_q) begin
                len_snap <= len_q;
            end
            if (sync && !sync_q) begin
                hi_snap <= run_q;
                gap_snap <= gap_q;
                rises <= rises + 16'h0001;
                gap_q <= 16'h0001;
            end else begin
                gap_q <= gap_q + 16'h0001;
            end
            for (int i = 0; i < 6; i++) begin
                run_q[i] <= ((sync && !sync_q) ? 16'h0000 : run_q[i]) + {15'h0000, gate[i]};
            end
        end
    end
endmodule : tpw_gate_model

// >>> verif/tb_top.sv
// testbench: drives tpw_timing over apb and checks timing at its pins.
// assumes the gate model beside it and the checker bound to the design.
module tb_top
    import tpw_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, sync, irq, err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd, sum;
    wire [5:0] gate; // a high on top, one design pin drives each bit
    logic [5:0][15:0] hi_snap;
    logic [15:0] gap_snap, len_snap, rises;
    logic [1:0] half; // half flag at two rises
    logic [15:0] exp_on [6] = '{16'h10, 16'h4C, 16'h64, 16'h0, 16'h0, 16'h5E};
    int err_total, checks, cyc, t0;
    int irqs; // interrupt pulses seen, settled at the falling edge
    tpw_timing u_dut (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .phase_a_high_out(gate[5]), .phase_a_low_out(gate[4]), .phase_b_high_out(gate[3]),
        .phase_b_low_out(gate[2]), .phase_c_high_out(gate[1]), .phase_c_low_out(gate[0]),
        .period_sync_pulse(sync), .sync_irq(irq)
    );
    tpw_gate_model u_model (.pclk, .presetn, .gate, .sync, .hi_snap, .gap_snap, .len_snap, .rises);
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    // watchdog on the falling edge, so reads at rising edges never race it
    always @(negedge pclk) begin
        cyc++;
        if (irq === 1'b1) irqs++;
        if (cyc == 8000) begin
            err_total++;
            summarize();
        end
    end
    task automatic summarize();
        $display("counts: checks=%0d err_total=%0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : summarize
    task automatic cmp_val(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
        end
    endtask : cmp_val
    task automatic cmp_near(input string what, input int exp, input int got, input int tol);
        checks++;
        if (got < exp - tol || got > exp + tol) begin
            err_total++;
            $display("[FAIL] %s expected %0d seen %0d", what, exp, got);
        end
    endtask : cmp_near
    // one apb transfer; starts after an edge so a release never meets a new setup
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // no assumed wait count: only the watchdog ends a lost answer
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic chk(input logic [7:0] a, input logic [31:0] e, input logic ee);
        apb(1'b0, a, 32'h0);
        cmp_val("rdata", e, rd);
        cmp_val("pslverr", {31'h0, ee}, {31'h0, err});
    endtask : chk
    // waits for k sync rises as the model sees them; the watchdog bounds it
    task automatic wait_sync(input int k);
        logic [15:0] r;
        repeat (k) begin
            r = rises;
            while (rises === r) begin
                @(posedge pclk);
            end
        end
    endtask : wait_sync
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        chk(TPW_OFS_MODE, 32'h0, 1'b0);
        chk(TPW_OFS_SYNC_WIDTH, 32'h27, 1'b0);
        apb(1'b1, TPW_OFS_STATUS, 32'hFFFFFFFF);
        chk(TPW_OFS_STATUS, 32'h0, 1'b0);
        chk(8'hFC, 32'h0, 1'b1);
        $display("test reset_values done");
        // dead time then period written first; b over range, c under the dead time
        apb(1'b1, TPW_OFS_DEAD_TIME, 32'h2);
        apb(1'b1, TPW_OFS_HALF_PERIOD, 32'h32);
        t0 = cyc;
        apb(1'b1, TPW_OFS_DUTY_A, 32'hA);
        apb(1'b1, TPW_OFS_DUTY_B, 32'h3C);
        apb(1'b1, TPW_OFS_DUTY_C, 32'h1);
        wait_sync(1);
        cmp_near("first_sync", 75, cyc - t0, 4);
        wait_sync(3);
        cmp_val("period", 32'h64, 32'(gap_snap));
        cmp_val("sync_width", 32'h28, 32'(len_snap));
        for (int i = 0; i < 6; i++) cmp_val("on_time", 32'(exp_on[i]), 32'(hi_snap[5 - i]));
        $display("test single_update done");
        apb(1'b1, TPW_OFS_SYNC_WIDTH, 32'h4);
        apb(1'b1, TPW_OFS_OUT_SEL, 32'h20);
        chk(TPW_OFS_OUT_SEL, 32'h20, 1'b0);
        wait_sync(3);
        cmp_val("sync_width", 32'h5, 32'(len_snap));
        cmp_val("on_time", 32'h0, 32'(hi_snap[5]));
        cmp_val("on_time", 32'h4C, 32'(hi_snap[4]));
        apb(1'b1, TPW_OFS_OUT_SEL, 32'h0);
        $display("test width_and_select done");
        apb(1'b1, TPW_OFS_MODE, 32'h40);
        chk(TPW_OFS_MODE, 32'h40, 1'b0);
        wait_sync(4);
        cmp_val("period", 32'h32, 32'(gap_snap));
        sum = 32'h0;
        for (int i = 0; i < 2; i++) begin
            wait_sync(1);
            sum += 32'(hi_snap[5]);
            apb(1'b0, TPW_OFS_STATUS, 32'h0);
            half[i] = rd[TPW_STAT_HALF_BIT];
        end
        cmp_val("half_flag", 32'h1, {31'h0, half[0] ^ half[1]});
        cmp_val("on_time", 32'h10, sum);
        $display("test double_update done");
        cmp_val("irq_count", 32'(rises), 32'(irqs));
        summarize();
    end
endmodule : tb_top
